// file: verilog/edge_gate_pkg.sv
// Constants and carrier types for the pin edge interrupt and wake gate block.
// Assumes a single core clock; register writes arrive on a simple I/O write port.
package edge_gate_pkg;
  localparam logic [5:0] IO_ADDR_EDGE_SEL = 6'h0c;
  localparam logic [5:0] IO_ADDR_PA_GATE = 6'h0d;
  localparam logic [5:0] IO_ADDR_OPTION = 6'h3e;
  localparam int CNT_EDGE_POS = 4;
  localparam int PB_EDGE_LSB = 2;
  localparam int PA_EDGE_LSB = 0;
  localparam int OPT_PB_SEL_POS = 0;
  localparam int OPT_PA_SEL_POS = 1;
  localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
  localparam logic [7:0] PA_GATE_RESET = 8'hff;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] PA_INPUT_MASK = 8'hd8;
  localparam logic [7:0] PA_WAKE_MASK = 8'hff;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    EDGE_BOTH = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_RSVD = 2'b11
  } edge_mode_t;

  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
  } io_write_t;

  typedef struct packed {
    logic cnt_req;
    logic pa_req;
    logic pb_req;
  } irq_pulse_t;
endpackage

// file: verilog/pin_sync.sv
// Two-stage synchroniser for a vector of pins.
// Assumes inputs may be asynchronous to the core clock.
`timescale 1ns/1ps
module pin_sync
  import edge_gate_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // pin_sync

// file: verilog/edge_detect.sv
// Edge qualifier: one-cycle pulse on the chosen edge of a synchronised level.
// Assumes i_level is already synchronous to the core clock.
`timescale 1ns/1ps
module edge_detect
  import edge_gate_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_level,
  input wire edge_mode_t i_mode,
  output logic o_pulse
);
  logic prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_level;
    end
  end

  assign rise = i_level & ~prev_reg;
  assign fall = ~i_level & prev_reg;

  always_comb begin
    case (i_mode)
      EDGE_BOTH: o_pulse = rise | fall;
      EDGE_RISE: o_pulse = rise;
      EDGE_FALL: o_pulse = fall;
      default: o_pulse = 1'b0;
    endcase
  end
endmodule // edge_detect

// file: verilog/pin_edge_irq_and_wake_gate.sv
// Edge select for counter and two pin interrupt channels, port A input/wake gating.
// Assumes pins asynchronous; counter bit synchronous; write port from the core I/O space.
`timescale 1ns/1ps
module pin_edge_irq_and_wake_gate
  import edge_gate_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire io_write_t i_io_wr,
  input wire logic i_emulator_mode,
  input wire logic i_counter_bit,
  input wire logic [7:0] i_porta_pins,
  input wire logic [7:0] i_portb_pins,
  input wire logic i_clr_pa_flag,
  input wire logic i_clr_pb_flag,
  input wire logic i_clr_cnt_flag,
  output irq_pulse_t o_irq_pulse,
  output logic o_pa_flag,
  output logic o_pb_flag,
  output logic o_cnt_flag,
  output logic [7:0] o_porta_input_en,
  output logic [7:0] o_porta_wake,
  output logic o_wake_req
);
  logic [7:0] edge_sel_reg;
  logic [7:0] pa_gate_reg;
  logic [7:0] option_reg;
  logic [7:0] pa_sync;
  logic [7:0] pb_sync;
  logic [7:0] pa_prev_reg;
  logic [7:0] pa_gate_eff;
  logic [7:0] pa_wake_next;
  logic cnt_prev_reg;
  logic cnt_pulse;
  logic pa_src;
  logic pb_src;
  logic pa_pulse;
  logic pb_pulse;
  logic pa_pulse_gated;
  logic pb_pulse_gated;
  logic [1:0] src_sel_prev_reg;
  logic pa_src_steady;
  logic pb_src_steady;

  // Write-only control registers
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      edge_sel_reg <= EDGE_SEL_RESET;
      pa_gate_reg <= PA_GATE_RESET;
      option_reg <= OPTION_RESET;
    end else if (i_io_wr.en) begin
      case (i_io_wr.addr)
        IO_ADDR_EDGE_SEL: edge_sel_reg <= i_io_wr.data;
        IO_ADDR_PA_GATE: pa_gate_reg <= i_io_wr.data;
        IO_ADDR_OPTION: option_reg <= i_io_wr.data;
        default: ;
      endcase
    end
  end

  // Emulator polarity: stored 0 enables
  assign pa_gate_eff = i_emulator_mode ? ~pa_gate_reg : pa_gate_reg;

  pin_sync #(.WIDTH(8)) u_pa_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d(i_porta_pins),
    .o_q(pa_sync)
  );

  pin_sync #(.WIDTH(8)) u_pb_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d(i_portb_pins),
    .o_q(pb_sync)
  );

  assign pb_src = option_reg[OPT_PB_SEL_POS] ? pb_sync[7] : pb_sync[0];
  assign pa_src = option_reg[OPT_PA_SEL_POS] ? pa_sync[5] : pa_sync[0];

  edge_detect u_pa_edge (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_level(pa_src),
    .i_mode(edge_mode_t'(edge_sel_reg[PA_EDGE_LSB +: 2])),
    .o_pulse(pa_pulse)
  );

  edge_detect u_pb_edge (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_level(pb_src),
    .i_mode(edge_mode_t'(edge_sel_reg[PB_EDGE_LSB +: 2])),
    .o_pulse(pb_pulse)
  );

  // Source select one cycle ago; switching pins is not an edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      src_sel_prev_reg <= {OPTION_RESET[OPT_PA_SEL_POS], OPTION_RESET[OPT_PB_SEL_POS]};
    end else begin
      src_sel_prev_reg <= {option_reg[OPT_PA_SEL_POS], option_reg[OPT_PB_SEL_POS]};
    end
  end

  assign pa_src_steady = (src_sel_prev_reg[1] == option_reg[OPT_PA_SEL_POS]);
  assign pb_src_steady = (src_sel_prev_reg[0] == option_reg[OPT_PB_SEL_POS]);

  // Port A pin zero and pin five interrupts pass only while their gate bit enables; port B is not gated
  assign pa_pulse_gated = pa_pulse & pa_src_steady &
    (option_reg[OPT_PA_SEL_POS] ? pa_gate_eff[5] : pa_gate_eff[0]);
  assign pb_pulse_gated = pb_pulse & pb_src_steady;

  // Counter bit edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_prev_reg <= 1'b0;
    end else begin
      cnt_prev_reg <= i_counter_bit;
    end
  end

  assign cnt_pulse = edge_sel_reg[CNT_EDGE_POS] ? (cnt_prev_reg & ~i_counter_bit)
                                                : (~cnt_prev_reg & i_counter_bit);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq_pulse <= '0;
    end else begin
      o_irq_pulse.cnt_req <= cnt_pulse;
      o_irq_pulse.pa_req <= pa_pulse_gated;
      o_irq_pulse.pb_req <= pb_pulse_gated;
    end
  end

  // Sticky request flags, set wins over clear
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pa_flag <= 1'b0;
      o_pb_flag <= 1'b0;
      o_cnt_flag <= 1'b0;
    end else begin
      o_pa_flag <= pa_pulse_gated | (o_pa_flag & ~i_clr_pa_flag);
      o_pb_flag <= pb_pulse_gated | (o_pb_flag & ~i_clr_pb_flag);
      o_cnt_flag <= cnt_pulse | (o_cnt_flag & ~i_clr_cnt_flag);
    end
  end

  // Per-pin wake on toggle, gated by its enable
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pa_prev_reg <= '0;
    end else begin
      pa_prev_reg <= pa_sync;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_wake
      assign pa_wake_next[gi] = PA_WAKE_MASK[gi] & pa_gate_eff[gi] &
                                (pa_sync[gi] ^ pa_prev_reg[gi]);
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_porta_input_en <= PA_GATE_RESET & PA_INPUT_MASK;
      o_porta_wake <= '0;
      o_wake_req <= 1'b0;
    end else begin
      o_porta_input_en <= pa_gate_eff & PA_INPUT_MASK;
      o_porta_wake <= pa_wake_next;
      o_wake_req <= |pa_wake_next;
    end
  end

  AST_CNT_EDGE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cnt_pulse |=> o_irq_pulse.cnt_req && o_cnt_flag)
    else $error("counter edge lost");
  AST_CNT_POL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (edge_sel_reg[CNT_EDGE_POS] && $rose(i_counter_bit)) |=> !o_irq_pulse.cnt_req)
    else $error("counter fired on wrong edge");
  AST_PB_RSVD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (edge_sel_reg[3:2] == 2'b11) |-> !pb_pulse)
    else $error("reserved edge mode fired");
  AST_PA_RISE_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (edge_sel_reg[1:0] == 2'b01 && pa_pulse) |-> pa_src)
    else $error("port A rising mode fired on fall");
  AST_PB_SRC: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !option_reg[OPT_PB_SEL_POS] |-> pb_src == pb_sync[0])
    else $error("port B source wrong");
  AST_PA_GATE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!option_reg[OPT_PA_SEL_POS] && !pa_gate_eff[0]) |=> !o_irq_pulse.pa_req)
    else $error("gated pin zero interrupt");
  AST_FLAG_SET_WINS: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (pa_pulse_gated && i_clr_pa_flag) |=> o_pa_flag)
    else $error("flag set lost to clear");
  AST_FLAG_CLR: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clr_pb_flag && !pb_pulse_gated) |=> !o_pb_flag)
    else $error("flag not cleared");
  AST_WAKE_GATE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !pa_gate_eff[2] |=> !o_porta_wake[2])
    else $error("gated wake passed");
  AST_EMU_INV: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_emulator_mode && pa_gate_reg[7]) |=> !o_porta_input_en[7])
    else $error("emulator polarity wrong");
  AST_PULSE_ONE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_irq_pulse.pb_req |=> !o_irq_pulse.pb_req || $changed(pb_src))
    else $error("request pulse too long");
  AST_PA_SRC_SWITCH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $changed(option_reg[OPT_PA_SEL_POS]) |=> !o_irq_pulse.pa_req)
    else $error("source switch gave port A request");
  AST_PB_SRC_SWITCH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $changed(option_reg[OPT_PB_SEL_POS]) |=> !o_irq_pulse.pb_req)
    else $error("source switch gave port B request");

  COV_PA_IRQ: cover property (@(posedge i_core_clk) disable iff (!i_nrst) o_irq_pulse.pa_req);
  COV_PB_SEVEN: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    option_reg[OPT_PB_SEL_POS] && o_irq_pulse.pb_req);
  COV_CNT_FALL: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    edge_sel_reg[CNT_EDGE_POS] && o_irq_pulse.cnt_req);
  COV_WAKE: cover property (@(posedge i_core_clk) disable iff (!i_nrst) o_wake_req);
endmodule // pin_edge_irq_and_wake_gate

// file: verification/ext_pins.sv
// Model of the external drivers on the port A and port B pins.
// Assumes the bench supplies pin levels; a crystal may sit on port A pins 6 and 7.
`timescale 1ns/1ps
module ext_pins (
  input wire logic i_core_clk,
  input wire logic i_xtal_on,
  input wire logic [7:0] i_pa_level,
  input wire logic [7:0] i_pb_level,
  output logic [7:0] o_porta_pins,
  output logic [7:0] o_portb_pins
);
  initial begin
    o_porta_pins = 8'h00;
    o_portb_pins = 8'h00;
  end
  always @(posedge i_core_clk) begin
    // Running crystal swings its two pins every cycle
    o_porta_pins <= i_xtal_on ? {~o_porta_pins[7:6], i_pa_level[5:0]} : i_pa_level;
    o_portb_pins <= i_pb_level;
  end
endmodule // ext_pins

// file: verification/pin_edge_irq_and_wake_gate_tb.sv
// Self-checking bench for the edge interrupt and wake gate block.
// Assumes the pin model ext_pins and the design package.
`timescale 1ns/1ps
module pin_edge_irq_and_wake_gate_tb;
  import edge_gate_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  io_write_t io_wr = '0;
  logic emu = 1'b0;
  logic cnt_bit = 1'b0;
  logic xtal = 1'b0;
  logic [2:0] clr = 3'b000;
  logic [7:0] pa_next = 8'h00;
  logic [7:0] pb_next = 8'h00;
  logic [7:0] pa_pins, pb_pins, in_en, wake;
  irq_pulse_t pulse;
  logic pa_flag, pb_flag, cnt_flag, wake_req;
  logic [7:0] esel = EDGE_SEL_RESET;
  logic [7:0] gate = PA_GATE_RESET;
  logic [7:0] opt = OPTION_RESET;
  logic [2:0] fl = 3'b000;
  logic [11:0] notes[$];
  logic [31:0] seed = 32'h7beaf91e;
  int fail_count = 0;
  int n_checks = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  ext_pins i_ext_pins (.i_core_clk(i_core_clk), .i_xtal_on(xtal), .i_pa_level(pa_next),
    .i_pb_level(pb_next), .o_porta_pins(pa_pins), .o_portb_pins(pb_pins));

  pin_edge_irq_and_wake_gate i_pin_edge_irq_and_wake_gate (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_io_wr(io_wr), .i_emulator_mode(emu), .i_counter_bit(cnt_bit), .i_porta_pins(pa_pins),
    .i_portb_pins(pb_pins), .i_clr_pa_flag(clr[1]), .i_clr_pb_flag(clr[0]), .i_clr_cnt_flag(clr[2]),
    .o_irq_pulse(pulse), .o_pa_flag(pa_flag), .o_pb_flag(pb_flag), .o_cnt_flag(cnt_flag),
    .o_porta_input_en(in_en), .o_porta_wake(wake), .o_wake_req(wake_req));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [7:0] geff();
    return emu ? ~gate : gate;
  endfunction

  function automatic logic hit(input logic [1:0] m, input logic o, input logic n);
    return (o != n) && (m == EDGE_BOTH || (m == EDGE_RISE && n) || (m == EDGE_FALL && !n));
  endfunction

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    io_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge i_core_clk);
    io_wr.en <= 1'b0;
    if (a == IO_ADDR_EDGE_SEL) esel = d;
    if (a == IO_ADDR_PA_GATE) gate = d;
    if (a == IO_ADDR_OPTION) opt = d;
    repeat (2) @(posedge i_core_clk);
    #1 check("input_en", {4'h0, in_en}, {4'h0, geff() & PA_INPUT_MASK});
  endtask

  task automatic step(input logic [7:0] pa, input logic [7:0] pb, input logic c);
    logic [7:0] g, w;
    logic ha, hb, hc;
    int sa, sb;
    g = geff();
    sa = opt[OPT_PA_SEL_POS] ? 5 : 0;
    sb = opt[OPT_PB_SEL_POS] ? 7 : 0;
    w = (pa ^ pa_next) & g & PA_WAKE_MASK;
    ha = hit(esel[1:0], pa_next[sa], pa[sa]) & g[sa];
    hb = hit(esel[3:2], pb_next[sb], pb[sb]);
    hc = (c != cnt_bit) && (esel[CNT_EDGE_POS] ? !c : c);
    if (hc) notes.push_back(12'h800);
    if (ha || hb || w != 8'h00) notes.push_back({1'b0, ha, hb, |w, w});
    fl = fl | {hc, ha, hb};
    @(posedge i_core_clk);
    pa_next <= pa;
    pb_next <= pb;
    cnt_bit <= c;
    repeat (8) @(posedge i_core_clk);
    check("flags", {9'h0, cnt_flag, pa_flag, pb_flag}, {9'h0, fl});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every result consumes the oldest note
  always @(negedge i_core_clk) begin
    if (i_nrst === 1'b1 && (pulse !== 3'b000 || wake_req !== 1'b0)) begin
      if (notes.size() == 0) check("spurious", {pulse, wake_req, wake}, 12'h000);
      else check("event", {pulse, wake_req, wake}, notes.pop_front());
    end
  end

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    #1 check("reset_en", {4'h0, in_en}, {4'h0, PA_GATE_RESET & PA_INPUT_MASK});
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      r = seed;
      if (r[3:0] == 4'h0) begin
        emu <= r[8];
        wr(IO_ADDR_EDGE_SEL, r[23:16]);
      end
      if (r[3:0] == 4'h1 || r[3:0] == 4'h4) wr(IO_ADDR_PA_GATE, r[31:24]);
      if (r[3:0] == 4'h2) wr(IO_ADDR_OPTION, r[15:8]);
      if (r[3:0] == 4'h3) wr(6'h0e, r[15:8]);
      seed = xs(seed);
      step(seed[7:0], seed[15:8], seed[16]);
      if (r[4]) begin
        @(posedge i_core_clk);
        clr <= r[7:5];
        @(posedge i_core_clk);
        clr <= 3'b000;
        fl = fl & ~r[7:5];
      end
    end
    emu <= 1'b0;
    wr(IO_ADDR_PA_GATE, gate & 8'h3f);
    xtal <= 1'b1;
    repeat (30) @(posedge i_core_clk);
    for (int k = 0; k < 20 && notes.size() != 0; k++) @(posedge i_core_clk);
    if (notes.size() != 0) check("pending", 12'(notes.size()), 12'h000);
    complete_run();
  end
endmodule // pin_edge_irq_and_wake_gate_tb
